/* hdl/timer_irq_pkg.sv */
// Shared constants and carriers for the timer interrupt flag and mask block.
// Assumes an 8-bit I/O register port and timer units on the same clock.
package timer_irq_pkg;

  // Register addresses on the I/O register port.
  localparam logic [7:0] LEGACY_FLAGS_ADDR = 8'h36;
  localparam logic [7:0] LEGACY_MASKS_ADDR = 8'h37;
  localparam logic [7:0] EXT_FLAGS_ADDR    = 8'h7C;
  localparam logic [7:0] EXT_MASKS_ADDR    = 8'h7D;

  // Values after reset.
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic       BIT_RESET  = 1'b0;

  // Bits of the legacy registers owned here; the others belong to 8-bit timers.
  localparam logic [7:0] LEGACY_OWNED = 8'h3C;
  // Bits of the extended registers that exist; 7 and 6 are unused.
  localparam logic [7:0] EXT_USED     = 8'h3F;

  // Field positions, legacy flag and mask registers.
  localparam int L_U1_CAP  = 5;
  localparam int L_U1_CMPA = 4;
  localparam int L_U1_CMPB = 3;
  localparam int L_U1_OVF  = 2;

  // Field positions, extended flag and mask registers.
  localparam int E_U3_CAP  = 5;
  localparam int E_U3_CMPA = 4;
  localparam int E_U3_CMPB = 3;
  localparam int E_U3_OVF  = 2;
  localparam int E_U3_CMPC = 1;
  localparam int E_U1_CMPC = 0;

  // Interrupt source numbering on the request and acknowledge vectors.
  localparam int SRC_U1_CAP  = 0;
  localparam int SRC_U1_CMPA = 1;
  localparam int SRC_U1_CMPB = 2;
  localparam int SRC_U1_OVF  = 3;
  localparam int SRC_U1_CMPC = 4;
  localparam int SRC_U3_CAP  = 5;
  localparam int SRC_U3_CMPA = 6;
  localparam int SRC_U3_CMPB = 7;
  localparam int SRC_U3_OVF  = 8;
  localparam int SRC_U3_CMPC = 9;
  localparam int NUM_SOURCES = 10;

  // Per-unit event order inside the block.
  localparam int EV_CAP  = 0;
  localparam int EV_CMPA = 1;
  localparam int EV_CMPB = 2;
  localparam int EV_CMPC = 3;
  localparam int EV_OVF  = 4;
  localparam int NUM_EV  = 5;
  localparam int NUM_UNITS = 2;

  // Status a 16-bit counter unit presents, all on the system clock.
  typedef struct packed {
    logic       tick;            // Timer clock enable, one cycle.
    logic [2:0] match;           // Comparator equal, channels C,B,A.
    logic [2:0] force_strobe;    // Forced compare strobe, channels C,B,A.
    logic       overflow;        // Counter wraps this tick.
    logic       mode_point;      // Overflow point of the current PWM mode.
    logic       nonpwm;          // Waveform mode is normal or clear on compare.
    logic       capture_is_top;  // Capture register sets the count top.
    logic       top_reached;     // Counter equals top this tick.
    logic       capture_rising;  // Capture edge select, 1 = rising.
  } unit_events_t;

  // One access on the I/O register port.
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       read;
    logic [7:0] wdata;
  } reg_access_t;

endpackage : timer_irq_pkg

/* hdl/irq_flag_cell.sv */
// One sticky interrupt flag with software and vector clears.
// Assumes set and clear strobes come from logic on the same clock.
`timescale 1ns/10ps
module irq_flag_cell (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  // Set and clear strobes
  input  wire logic i_set,
  input  wire logic i_clear_sw,
  input  wire logic i_clear_vec,
  // Flag state
  output logic      o_flag
);

  logic flag_q;
  logic flag_d;

  // A set in the same cycle as either clear wins, so no event is dropped.
  always_comb begin
    flag_d = flag_q;
    if (i_clear_sw || i_clear_vec) begin
      flag_d = 1'b0; // RULE_10
    end
    if (i_set) begin
      flag_d = 1'b1; // RULE_21
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      flag_q <= timer_irq_pkg::BIT_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule : irq_flag_cell

/* hdl/timer_irq_flags.sv */
// Interrupt flags and masks for the two 16-bit timer units (one and three).
// Assumes counters and comparators on i_mclk; capture pins are asynchronous.
//
// How it works
// RULE_01: Unit-one overflow request needs legacy mask bit 2, global enable, flag.
// RULE_02: Extended mask bit 5 enables the unit-three capture request.
// RULE_03: Extended mask bit 4 enables the unit-three compare-A request.
// RULE_04: Extended mask bit 3 enables the unit-three compare-B request.
// RULE_05: Extended mask bit 2 enables the unit-three overflow request.
// RULE_06: Extended mask bit 1 enables the unit-three compare-C request.
// RULE_07: Extended mask bit 0 enables the unit-one compare-C request.
// RULE_08: Extended mask register is absent in legacy-compatibility mode.
// RULE_09: Unit-one capture flag sets on pin edge, or at top if capture is top.
// RULE_10: Flags clear on vector execution or software write of one.
// RULE_11: Unit-one compare-A flag sets one timer cycle after the match.
// RULE_12: A forced compare strobe never sets a compare flag.
// RULE_13: Unit-one compare-B flag sets one timer cycle after the match.
// RULE_14: Unit-one overflow flag follows overflow, or the mode's own point.
// RULE_15: Unit-three capture flag sets on pin edge, or at top.
// RULE_16: Unit-three compare A, B, C flags set one timer cycle after match.
// RULE_17: Unit-three overflow flag follows overflow, or the mode's own point.
// RULE_18: Unit-one compare-C flag sets one timer cycle after the match.
// RULE_19: Legacy mask bits 5, 4, 3 enable unit-one capture, A, B requests.
// RULE_20: Extended bits 7 and 6 read zero and ignore writes.
// RULE_21: A set and a clear in one cycle leave the flag set.
`timescale 1ns/10ps
module timer_irq_flags (
  // Clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_resetn,
  // I/O register port
  input  wire timer_irq_pkg::reg_access_t   i_reg,
  output logic [7:0]                        o_rdata,
  // Timer unit status
  input  wire timer_irq_pkg::unit_events_t  i_unit1,
  input  wire timer_irq_pkg::unit_events_t  i_unit3,
  // Capture pins
  input  wire logic                         i_unit1_capture_pin,
  input  wire logic                         i_unit3_capture_pin,
  // Configuration
  input  wire logic                         i_compat_mode,
  // Processor core
  input  wire logic                         i_global_enable,
  input  wire logic [9:0]                   i_vector_ack,
  output logic [9:0]                        o_irq_req
);

  timer_irq_pkg::unit_events_t ev   [timer_irq_pkg::NUM_UNITS];
  logic                        pins [timer_irq_pkg::NUM_UNITS];
  logic [4:0]                  unit_set [timer_irq_pkg::NUM_UNITS];

  assign ev[0]   = i_unit1;
  assign ev[1]   = i_unit3;
  assign pins[0] = i_unit1_capture_pin;
  assign pins[1] = i_unit3_capture_pin;

  // Event detection, identical for both units.
  for (genvar u = 0; u < timer_irq_pkg::NUM_UNITS; u++) begin : g_unit
    logic       sync1_q;
    logic       sync2_q;
    logic       pin_prev_q;
    logic [2:0] pend_q;
    logic [2:0] pend_d;
    logic       pin_edge;
    logic [2:0] real_match;
    logic [4:0] set_c;

    always_comb begin
      // The forced strobe is masked off the comparator output.
      real_match = ev[u].match & ~ev[u].force_strobe; // RULE_12
      pend_d = pend_q;
      if (ev[u].tick) begin
        // The match is held one timer cycle and raised at the next tick.
        pend_d = real_match; // RULE_11 RULE_13 RULE_16 RULE_18
      end
      pin_edge = ev[u].capture_rising ? (sync2_q && !pin_prev_q)
                                      : (!sync2_q && pin_prev_q);
      set_c = 5'h00;
      // With capture as top the pin is ignored and top sets the flag.
      set_c[timer_irq_pkg::EV_CAP] = ev[u].capture_is_top
        ? (ev[u].tick && ev[u].top_reached)
        : pin_edge; // RULE_09 RULE_15
      set_c[timer_irq_pkg::EV_CMPA] = ev[u].tick && pend_q[0];
      set_c[timer_irq_pkg::EV_CMPB] = ev[u].tick && pend_q[1];
      set_c[timer_irq_pkg::EV_CMPC] = ev[u].tick && pend_q[2];
      set_c[timer_irq_pkg::EV_OVF]  = ev[u].tick &&
        (ev[u].nonpwm ? ev[u].overflow : ev[u].mode_point); // RULE_14 RULE_17
    end

    // Two flops guard the edge logic against a metastable pin sample.
    always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
        sync1_q    <= timer_irq_pkg::BIT_RESET;
        sync2_q    <= timer_irq_pkg::BIT_RESET;
        pin_prev_q <= timer_irq_pkg::BIT_RESET;
        pend_q     <= 3'h0;
      end else begin
        sync1_q    <= pins[u];
        sync2_q    <= sync1_q;
        pin_prev_q <= sync2_q;
        pend_q     <= pend_d;
      end
    end

    assign unit_set[u] = set_c;
  end

  // Source vectors: set strobes, software clears, enables.
  logic [9:0] src_set;
  logic [9:0] src_clear_sw;
  logic [9:0] src_flag;
  logic [9:0] src_enable;
  logic       legacy_flags_wr;
  logic       ext_flags_wr;
  logic [7:0] legacy_masks_q;
  logic [7:0] legacy_masks_d;
  logic [7:0] ext_masks_q;
  logic [7:0] ext_masks_d;
  logic [7:0] ext_masks_eff;

  // The pin-edge capture set is already on the system clock, so it needs no tick.
  always_comb begin
    src_set = 10'h000;
    src_set[timer_irq_pkg::SRC_U1_CAP]  = unit_set[0][timer_irq_pkg::EV_CAP];
    src_set[timer_irq_pkg::SRC_U1_CMPA] = unit_set[0][timer_irq_pkg::EV_CMPA];
    src_set[timer_irq_pkg::SRC_U1_CMPB] = unit_set[0][timer_irq_pkg::EV_CMPB];
    src_set[timer_irq_pkg::SRC_U1_OVF]  = unit_set[0][timer_irq_pkg::EV_OVF];
    src_set[timer_irq_pkg::SRC_U1_CMPC] = unit_set[0][timer_irq_pkg::EV_CMPC];
    src_set[timer_irq_pkg::SRC_U3_CAP]  = unit_set[1][timer_irq_pkg::EV_CAP];
    src_set[timer_irq_pkg::SRC_U3_CMPA] = unit_set[1][timer_irq_pkg::EV_CMPA];
    src_set[timer_irq_pkg::SRC_U3_CMPB] = unit_set[1][timer_irq_pkg::EV_CMPB];
    src_set[timer_irq_pkg::SRC_U3_OVF]  = unit_set[1][timer_irq_pkg::EV_OVF];
    src_set[timer_irq_pkg::SRC_U3_CMPC] = unit_set[1][timer_irq_pkg::EV_CMPC];
  end

  assign legacy_flags_wr = i_reg.write &&
                           (i_reg.addr == timer_irq_pkg::LEGACY_FLAGS_ADDR);
  assign ext_flags_wr    = i_reg.write &&
                           (i_reg.addr == timer_irq_pkg::EXT_FLAGS_ADDR);

  // A written one clears; a written zero leaves the flag alone.
  always_comb begin
    src_clear_sw = 10'h000;
    if (legacy_flags_wr) begin
      src_clear_sw[timer_irq_pkg::SRC_U1_CAP]  =
        i_reg.wdata[timer_irq_pkg::L_U1_CAP]; // RULE_10
      src_clear_sw[timer_irq_pkg::SRC_U1_CMPA] =
        i_reg.wdata[timer_irq_pkg::L_U1_CMPA];
      src_clear_sw[timer_irq_pkg::SRC_U1_CMPB] =
        i_reg.wdata[timer_irq_pkg::L_U1_CMPB];
      src_clear_sw[timer_irq_pkg::SRC_U1_OVF]  =
        i_reg.wdata[timer_irq_pkg::L_U1_OVF];
    end
    if (ext_flags_wr) begin
      src_clear_sw[timer_irq_pkg::SRC_U3_CAP]  =
        i_reg.wdata[timer_irq_pkg::E_U3_CAP]; // RULE_10
      src_clear_sw[timer_irq_pkg::SRC_U3_CMPA] =
        i_reg.wdata[timer_irq_pkg::E_U3_CMPA];
      src_clear_sw[timer_irq_pkg::SRC_U3_CMPB] =
        i_reg.wdata[timer_irq_pkg::E_U3_CMPB];
      src_clear_sw[timer_irq_pkg::SRC_U3_OVF]  =
        i_reg.wdata[timer_irq_pkg::E_U3_OVF];
      src_clear_sw[timer_irq_pkg::SRC_U3_CMPC] =
        i_reg.wdata[timer_irq_pkg::E_U3_CMPC];
      src_clear_sw[timer_irq_pkg::SRC_U1_CMPC] =
        i_reg.wdata[timer_irq_pkg::E_U1_CMPC];
    end
  end

  // One cell per source keeps the set-over-clear policy in one place.
  for (genvar s = 0; s < timer_irq_pkg::NUM_SOURCES; s++) begin : g_flag
    irq_flag_cell u_flag (
      .i_mclk      (i_mclk),
      .i_resetn    (i_resetn),
      .i_set       (src_set[s]),
      .i_clear_sw  (src_clear_sw[s]),
      .i_clear_vec (i_vector_ack[s]), // RULE_10
      .o_flag      (src_flag[s])
    );
  end

  // Mask registers. Writes to the extended mask are dropped in
  // compatibility mode; its stored value is kept but has no effect.
  always_comb begin
    legacy_masks_d = legacy_masks_q;
    ext_masks_d    = ext_masks_q;
    if (i_reg.write && (i_reg.addr == timer_irq_pkg::LEGACY_MASKS_ADDR)) begin
      legacy_masks_d = i_reg.wdata & timer_irq_pkg::LEGACY_OWNED;
    end
    if (i_reg.write && !i_compat_mode &&
        (i_reg.addr == timer_irq_pkg::EXT_MASKS_ADDR)) begin // RULE_08
      ext_masks_d = i_reg.wdata & timer_irq_pkg::EXT_USED; // RULE_20
    end
  end

  assign ext_masks_eff = i_compat_mode ? 8'h00 : ext_masks_q; // RULE_08

  always_comb begin
    src_enable = 10'h000;
    src_enable[timer_irq_pkg::SRC_U1_CAP]  =
      legacy_masks_q[timer_irq_pkg::L_U1_CAP]; // RULE_19
    src_enable[timer_irq_pkg::SRC_U1_CMPA] =
      legacy_masks_q[timer_irq_pkg::L_U1_CMPA]; // RULE_19
    src_enable[timer_irq_pkg::SRC_U1_CMPB] =
      legacy_masks_q[timer_irq_pkg::L_U1_CMPB]; // RULE_19
    src_enable[timer_irq_pkg::SRC_U1_OVF]  =
      legacy_masks_q[timer_irq_pkg::L_U1_OVF]; // RULE_01
    src_enable[timer_irq_pkg::SRC_U3_CAP]  =
      ext_masks_eff[timer_irq_pkg::E_U3_CAP]; // RULE_02
    src_enable[timer_irq_pkg::SRC_U3_CMPA] =
      ext_masks_eff[timer_irq_pkg::E_U3_CMPA]; // RULE_03
    src_enable[timer_irq_pkg::SRC_U3_CMPB] =
      ext_masks_eff[timer_irq_pkg::E_U3_CMPB]; // RULE_04
    src_enable[timer_irq_pkg::SRC_U3_OVF]  =
      ext_masks_eff[timer_irq_pkg::E_U3_OVF]; // RULE_05
    src_enable[timer_irq_pkg::SRC_U3_CMPC] =
      ext_masks_eff[timer_irq_pkg::E_U3_CMPC]; // RULE_06
    src_enable[timer_irq_pkg::SRC_U1_CMPC] =
      ext_masks_eff[timer_irq_pkg::E_U1_CMPC]; // RULE_07
  end

  // Requests and read data are registered, so each lags its cause by one
  // cycle; the core must not treat a request as live in the ack cycle or the one after.
  logic [9:0] irq_q;
  logic [9:0] irq_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    irq_d = src_flag & src_enable & {10{i_global_enable}}; // RULE_01
  end

  always_comb begin
    rdata_d = 8'h00;
    if (i_reg.read) begin
      case (i_reg.addr)
        timer_irq_pkg::LEGACY_FLAGS_ADDR: begin
          rdata_d[timer_irq_pkg::L_U1_CAP]  =
            src_flag[timer_irq_pkg::SRC_U1_CAP];
          rdata_d[timer_irq_pkg::L_U1_CMPA] =
            src_flag[timer_irq_pkg::SRC_U1_CMPA];
          rdata_d[timer_irq_pkg::L_U1_CMPB] =
            src_flag[timer_irq_pkg::SRC_U1_CMPB];
          rdata_d[timer_irq_pkg::L_U1_OVF]  =
            src_flag[timer_irq_pkg::SRC_U1_OVF];
        end
        timer_irq_pkg::LEGACY_MASKS_ADDR: begin
          rdata_d = legacy_masks_q;
        end
        timer_irq_pkg::EXT_FLAGS_ADDR: begin
          rdata_d[timer_irq_pkg::E_U3_CAP]  =
            src_flag[timer_irq_pkg::SRC_U3_CAP];
          rdata_d[timer_irq_pkg::E_U3_CMPA] =
            src_flag[timer_irq_pkg::SRC_U3_CMPA];
          rdata_d[timer_irq_pkg::E_U3_CMPB] =
            src_flag[timer_irq_pkg::SRC_U3_CMPB];
          rdata_d[timer_irq_pkg::E_U3_OVF]  =
            src_flag[timer_irq_pkg::SRC_U3_OVF];
          rdata_d[timer_irq_pkg::E_U3_CMPC] =
            src_flag[timer_irq_pkg::SRC_U3_CMPC];
          rdata_d[timer_irq_pkg::E_U1_CMPC] =
            src_flag[timer_irq_pkg::SRC_U1_CMPC];
        end
        timer_irq_pkg::EXT_MASKS_ADDR: begin
          rdata_d = ext_masks_eff & timer_irq_pkg::EXT_USED; // RULE_20
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      legacy_masks_q <= timer_irq_pkg::REG_RESET;
      ext_masks_q    <= timer_irq_pkg::REG_RESET;
    end else begin
      legacy_masks_q <= legacy_masks_d;
      ext_masks_q    <= ext_masks_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      irq_q <= 10'h000;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rdata_q <= timer_irq_pkg::REG_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_irq_req = irq_q;
  assign o_rdata   = rdata_q;

endmodule : timer_irq_flags

/* testbench/timer_irq_flags_assertions.sv */
// Checker for the timer interrupt flag and mask block, port view only.
// Assumes one clock; the mask shadow mirrors writes seen at the port.
`timescale 1ns/10ps
module timer_irq_flags_assertions (
  // Clock and reset
  input wire logic                        i_mclk,
  input wire logic                        i_resetn,
  // Register port
  input wire timer_irq_pkg::reg_access_t  i_reg,
  input wire logic [7:0]                  o_rdata,
  // Timer units and pins
  input wire timer_irq_pkg::unit_events_t i_unit1,
  input wire timer_irq_pkg::unit_events_t i_unit3,
  input wire logic                        i_unit1_capture_pin,
  input wire logic                        i_unit3_capture_pin,
  // Configuration and core
  input wire logic                        i_compat_mode,
  input wire logic                        i_global_enable,
  input wire logic [9:0]                  i_vector_ack,
  input wire logic [9:0]                  o_irq_req
);
  logic [7:0] lmask_q;
  logic [7:0] lmask_d;
  logic [7:0] emask_q;
  logic [7:0] emask_d;

  // The shadow lets request checks know the enables without seeing inside.
  always_comb begin
    lmask_d = lmask_q;
    emask_d = emask_q;
    if (i_reg.write && i_reg.addr == timer_irq_pkg::LEGACY_MASKS_ADDR) begin
      lmask_d = i_reg.wdata;
    end
    if (i_reg.write && i_reg.addr == timer_irq_pkg::EXT_MASKS_ADDR &&
        !i_compat_mode) begin
      emask_d = i_reg.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      lmask_q <= 8'h00;
      emask_q <= 8'h00;
    end else begin
      lmask_q <= lmask_d;
      emask_q <= emask_d;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  chk_ext_pad: assert property (
    i_reg.read && i_reg.addr == timer_irq_pkg::EXT_FLAGS_ADDR
    |=> o_rdata[7:6] == 2'b00) else $error("extended pad bits not zero");
  chk_mask_readback: assert property (
    i_reg.read && i_reg.addr == timer_irq_pkg::EXT_MASKS_ADDR && !i_compat_mode
    |=> o_rdata == (emask_q & 8'h3F)) else $error("mask read back wrong");
  chk_compat_hide: assert property (
    i_reg.read && i_reg.addr == timer_irq_pkg::EXT_MASKS_ADDR && i_compat_mode
    |=> o_rdata == 8'h00) else $error("mask visible in compat mode");
  chk_global_gate: assert property (
    !i_global_enable |=> o_irq_req == 10'h000)
    else $error("request without global enable");
  chk_u1_ovf_req: assert property (
    i_unit1.tick && i_unit1.overflow && i_unit1.nonpwm
    ##1 (i_global_enable && lmask_q[2]) |=> o_irq_req[3])
    else $error("overflow request missing");
  chk_u3_cmpa_req: assert property (
    i_unit3.tick && i_unit3.match[0] && !i_unit3.force_strobe[0]
    ##1 i_unit3.tick ##1 (i_global_enable && emask_q[4] && !i_compat_mode)
    |=> o_irq_req[6]) else $error("compare request missing");
  chk_u1_cap_top: assert property (
    i_unit1.tick && i_unit1.capture_is_top && i_unit1.top_reached
    ##1 (i_global_enable && lmask_q[5]) |=> o_irq_req[0])
    else $error("capture at top request missing");
  chk_u1_cmpc_req: assert property (
    i_unit1.tick && i_unit1.match[2] && !i_unit1.force_strobe[2]
    ##1 i_unit1.tick ##1 (i_global_enable && emask_q[0] && !i_compat_mode)
    |=> o_irq_req[4]) else $error("compare C request missing");
  chk_ack_clears: assert property (
    i_vector_ack[8] && !i_unit3.tick ##1 !i_unit3.tick |=> !o_irq_req[8])
    else $error("vector ack did not clear");
  chk_w1c_clears: assert property (
    i_reg.write && i_reg.addr == timer_irq_pkg::LEGACY_FLAGS_ADDR &&
    i_reg.wdata[2] && !i_unit1.tick ##1 !i_unit1.tick |=> !o_irq_req[3])
    else $error("write one did not clear");
endmodule : timer_irq_flags_assertions

bind timer_irq_flags timer_irq_flags_assertions i_chk (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg(i_reg), .o_rdata(o_rdata),
  .i_unit1(i_unit1), .i_unit3(i_unit3),
  .i_unit1_capture_pin(i_unit1_capture_pin),
  .i_unit3_capture_pin(i_unit3_capture_pin),
  .i_compat_mode(i_compat_mode), .i_global_enable(i_global_enable),
  .i_vector_ack(i_vector_ack), .o_irq_req(o_irq_req));

/* testbench/cpu_vector_model.sv */
// Model of the processor core taking interrupt vectors.
// Assumes requests are levels; it waits out the two-cycle drop after an ack.
`timescale 1ns/10ps
module cpu_vector_model (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  // Control from the bench
  input  wire logic       i_on,
  input  wire logic [3:0] i_delay,
  // Interrupt lines
  input  wire logic [9:0] i_irq_req,
  output logic [9:0]      o_vector_ack = 10'h000
);
  int wait_cnt = 0;

  always @(posedge i_mclk) begin
    o_vector_ack <= 10'h000;
    if (!i_resetn || !i_on) begin
      wait_cnt <= 0;
    end else if (wait_cnt < 0) begin
      wait_cnt <= wait_cnt + 1;
    end else if (i_irq_req != 10'h000) begin
      if (wait_cnt < int'(i_delay)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        o_vector_ack <= i_irq_req & (~i_irq_req + 10'h001);
        wait_cnt <= -3;
      end
    end
  end
endmodule : cpu_vector_model

/* testbench/tb_top.sv */
// Self-checking bench for the timer interrupt flag and mask block.
// Assumes the checker is bound in and the core model answers vectors.
`timescale 1ns/10ps
`define CHECK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin \
  err_total++; $display("wrong value at %0t: %s", $time, msg); end end
module tb_top;
  logic                        mclk = 1'b0;
  logic                        rst_n = 1'b0;
  timer_irq_pkg::reg_access_t  reg_req = '0;
  timer_irq_pkg::unit_events_t u1_ev = '0;
  timer_irq_pkg::unit_events_t u3_ev = '0;
  timer_irq_pkg::unit_events_t ev;
  logic                        cap_pin1 = 1'b0;
  logic                        cap_pin3 = 1'b0;
  logic                        compat = 1'b0;
  logic                        gen = 1'b0;
  logic                        ack_on = 1'b0;
  logic [3:0]                  ack_delay = 4'h7;
  logic [9:0]                  ack;
  logic [9:0]                  irq;
  logic [7:0]                  rdata;
  logic [7:0]                  lm;
  logic [7:0]                  em;
  logic                        g;
  logic [7:0]                  exp_q[$];
  bit                          rd_pend = 1'b0;
  int                          err_total = 0;
  int                          n_checks = 0;

  always #5 mclk = ~mclk;

  timer_irq_flags i_dut (
    .i_mclk(mclk), .i_resetn(rst_n), .i_reg(reg_req), .o_rdata(rdata),
    .i_unit1(u1_ev), .i_unit3(u3_ev), .i_unit1_capture_pin(cap_pin1),
    .i_unit3_capture_pin(cap_pin3), .i_compat_mode(compat),
    .i_global_enable(gen), .i_vector_ack(ack), .o_irq_req(irq));

  cpu_vector_model i_core (
    .i_mclk(mclk), .i_resetn(rst_n), .i_on(ack_on), .i_delay(ack_delay),
    .i_irq_req(irq), .o_vector_ack(ack));

  // Read data lands one cycle after the read is taken.
  always @(posedge mclk) begin
    if (rd_pend) `CHECK(rdata, exp_q.pop_front(), "read data")
    rd_pend = reg_req.read;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{addr: a, write: w, read: !w, wdata: d};
    @(posedge mclk);
    reg_req <= '0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd

  // Compares need a second tick to turn the armed match into a flag.
  task automatic pulse(input timer_irq_pkg::unit_events_t e);
    @(posedge mclk);
    u1_ev <= e;
    u3_ev <= e;
    @(posedge mclk);
    u1_ev <= '{tick: 1'b1, default: '0};
    u3_ev <= '{tick: 1'b1, default: '0};
    @(posedge mclk);
    u1_ev <= '0;
    u3_ev <= '0;
  endtask : pulse

  function automatic logic [9:0] want(input logic [7:0] l, input logic [7:0] e,
                                      input logic ge);
    want = {e[1], e[2], e[3], e[4], e[5], e[0], l[2], l[3], l[4], l[5]}
           & {10{ge}};
  endfunction : want

  // The span is several times the length of the sequence below.
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'hAE853F01));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'h36 + 8'(i), 8'h00);
    rd(8'h7C, 8'h00);
    rd(8'h7D, 8'h00);
    bus(1'b1, timer_irq_pkg::LEGACY_MASKS_ADDR, 8'hFF);
    bus(1'b1, timer_irq_pkg::EXT_MASKS_ADDR, 8'hFF);
    gen <= 1'b1;
    ev = '{tick: 1'b1, match: 3'b111, overflow: 1'b1, nonpwm: 1'b1,
           capture_is_top: 1'b1, top_reached: 1'b1, default: '0};
    pulse(ev);
    rd(timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'h3C);
    rd(timer_irq_pkg::EXT_FLAGS_ADDR, 8'h3F);
    for (int i = 0; i < 4; i++) begin
      lm = 8'($urandom);
      em = 8'($urandom);
      g = 1'($urandom);
      bus(1'b1, timer_irq_pkg::LEGACY_MASKS_ADDR, lm);
      bus(1'b1, timer_irq_pkg::EXT_MASKS_ADDR, em);
      gen <= g;
      rd(timer_irq_pkg::LEGACY_MASKS_ADDR, lm & 8'h3C);
      rd(timer_irq_pkg::EXT_MASKS_ADDR, em & 8'h3F);
      @(negedge mclk);
      `CHECK(irq, want(lm, em, g), "request vector")
    end
    bus(1'b1, timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'h04);
    rd(timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'h38);
    bus(1'b1, timer_irq_pkg::EXT_FLAGS_ADDR, 8'hC1);
    rd(timer_irq_pkg::EXT_FLAGS_ADDR, 8'h3E);
    bus(1'b1, timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'hFF);
    bus(1'b1, timer_irq_pkg::EXT_FLAGS_ADDR, 8'hFF);
    // Matches ride with the strobes and are masked off; overflow is ignored in PWM modes.
    pulse('{tick: 1'b1, match: 3'b111, force_strobe: 3'b111,
            overflow: 1'b1, default: '0});
    rd(timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'h00);
    rd(timer_irq_pkg::EXT_FLAGS_ADDR, 8'h00);
    compat <= 1'b1;
    bus(1'b1, timer_irq_pkg::EXT_MASKS_ADDR, 8'h3F);
    rd(timer_irq_pkg::EXT_MASKS_ADDR, 8'h00);
    compat <= 1'b0;
    rd(timer_irq_pkg::EXT_MASKS_ADDR, em & 8'h3F);
    // Edge select is falling here, so only the release counts.
    cap_pin1 <= 1'b1;
    cap_pin3 <= 1'b1;
    repeat (4) @(posedge mclk);
    cap_pin1 <= 1'b0;
    cap_pin3 <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'h20);
    rd(timer_irq_pkg::EXT_FLAGS_ADDR, 8'h20);
    bus(1'b1, timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'hFF);
    bus(1'b1, timer_irq_pkg::EXT_FLAGS_ADDR, 8'hFF);
    u1_ev <= '{capture_rising: 1'b1, default: '0};
    u3_ev <= '{capture_rising: 1'b1, default: '0};
    cap_pin1 <= 1'b1;
    cap_pin3 <= 1'b1;
    repeat (6) @(posedge mclk);
    pulse('{tick: 1'b1, mode_point: 1'b1, default: '0});
    rd(timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'h24);
    rd(timer_irq_pkg::EXT_FLAGS_ADDR, 8'h24);
    bus(1'b1, timer_irq_pkg::LEGACY_MASKS_ADDR, 8'hFF);
    bus(1'b1, timer_irq_pkg::EXT_MASKS_ADDR, 8'hFF);
    gen <= 1'b1;
    ack_on <= 1'b1;
    pulse(ev);
    repeat (200) @(posedge mclk);
    rd(timer_irq_pkg::LEGACY_FLAGS_ADDR, 8'h00);
    rd(timer_irq_pkg::EXT_FLAGS_ADDR, 8'h00);
    @(negedge mclk);
    `CHECK(irq, 10'h000, "requests after vectors")
    ack_on <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(timer_irq_pkg::LEGACY_MASKS_ADDR, 8'h00);
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule : tb_top
